// File: smg_pkg.sv
// Shared constants and types for the SMBus control port with two GPIO pins.
package smg_pkg;

  // Link clock period, used to turn the glitch width into cycles.
  localparam int LINK_PERIOD_PS = 12000;
  localparam int GLITCH_NS = 50;
  // Enough samples that a 50 ns pulse can never fill the window.
  localparam int GLITCH_CYC = GLITCH_NS * 1000 / LINK_PERIOD_PS + 2;
  localparam int GF_W = 3;
  localparam logic [GF_W-1:0] GF_MAX = GF_W'(GLITCH_CYC - 1);

  // Slave addresses.
  localparam logic [6:0] BCAST_ADDR = 7'h5D;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [1:0] OWN_TOP = 2'h2;

  // Three-level strap codes.
  localparam logic [1:0] PIN_L = 2'h0;
  localparam logic [1:0] PIN_H = 2'h1;
  localparam logic [1:0] PIN_NC = 2'h2;

  // Low five address bits, indexed by 9*pin2 + 3*pin1 + pin0.
  localparam logic [4:0] ADDR_LUT [0:26] = '{
    5'h04, 5'h07, 5'h06, 5'h19, 5'h05, 5'h01, 5'h00, 5'h03, 5'h02,
    5'h14, 5'h17, 5'h16, 5'h18, 5'h15, 5'h11, 5'h10, 5'h13, 5'h12,
    5'h0C, 5'h0F, 5'h0E, 5'h1A, 5'h0D, 5'h09, 5'h08, 5'h0B, 5'h0A};

  // Register indices; the Avalon byte address is four times these.
  localparam logic [1:0] REG_FAULT = 2'h0;
  localparam logic [1:0] REG_GPIO = 2'h1;
  localparam logic [1:0] REG_CFG = 2'h2;
  localparam logic [1:0] REG_SW = 2'h3;
  localparam logic [7:0] REG_RST [0:3] = '{8'h00, 8'h03, 8'h13, 8'h00};

  // Field positions.
  localparam int DRV_LSB = 0;
  localparam int LVL_LSB = 4;
  localparam int CFG_DIR_LSB = 0;
  localparam int CFG_PP_LSB = 2;
  localparam int CFG_BCAST = 4;
  localparam int CMD_SEL_LSB = 0;
  localparam int BCAST_SNAP_BIT = 8 * 2 + CFG_BCAST;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_READ, ST_WAIT
  } smg_state_t;

endpackage : smg_pkg

// File: smg_gpio_if.sv
// Configuration and readback bundle between the core and the GPIO driver.
`timescale 1ns/1ps
`default_nettype none

interface smg_gpio_if;
  logic [1:0] dir_in;
  logic [1:0] push_pull;
  logic [1:0] drive;
  logic [1:0] level;
  modport ctl (output dir_in, output push_pull, output drive, input level);
  modport drv (input dir_in, input push_pull, input drive, output level);
endinterface : smg_gpio_if

`default_nettype wire

// File: smg_glitch_filter.sv
// Synchroniser and spike filter for one upstream bus line.
`timescale 1ns/1ps
`default_nettype none

module smg_glitch_filter
  import smg_pkg::*;
(
  // Link clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw line and filtered level.
  input wire logic pin,
  output logic level
);

  logic s1_q, s2_q, lvl_q;
  logic [GF_W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'h1;
      s2_q <= 1'h1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || s2_q == lvl_q) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= (cnt_q == GF_MAX) ? '0 : cnt_q + GF_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q <= 1'h1;
    end else if (s2_q != lvl_q && cnt_q == GF_MAX) begin
      lvl_q <= s2_q;
    end
  end

  assign level = lvl_q;

  glitch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(lvl_q) |-> $past(cnt_q) == GF_MAX && $past(s2_q) == lvl_q)
    else $error("Filtered level changed before the window filled.");

endmodule : smg_glitch_filter

`default_nettype wire

// File: smg_gpio_drv.sv
// Output stages and level samplers of the two general-purpose pins.
`timescale 1ns/1ps
`default_nettype none

module smg_gpio_drv
  import smg_pkg::*;
(
  // System clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Configuration from the register file.
  smg_gpio_if.drv gp,
  // Pin signals, bit 0 is pin one.
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe
);

  logic [1:0] s1_q, s2_q, o_q, oe_q;

  wire logic [1:0] oe_d = ~gp.dir_in & (gp.push_pull | ~gp.drive);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_q <= 2'h0;
      o_q <= 2'h0;
    end else begin
      oe_q <= oe_d;
      o_q <= gp.drive & gp.push_pull;
    end
  end

  always_ff @(posedge clk) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
  end

  assign pin_o = o_q;
  assign pin_oe = oe_q;
  assign gp.level = s2_q;

  gpio_input_a: assert property (@(posedge clk) disable iff (!rst_n)
    gp.dir_in != 2'h0 |=> (pin_oe & $past(gp.dir_in)) == 2'h0)
    else $error("An input pin is being driven.");

  open_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (pin_oe & pin_o & ~$past(gp.push_pull)) == 2'h0)
    else $error("An open-drain pin drives high.");

  push_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (~$past(gp.dir_in) & $past(gp.push_pull) & ~pin_oe) == 2'h0)
    else $error("A push-pull output is not driven.");

endmodule : smg_gpio_drv

`default_nettype wire

// File: smg_top.sv
// SMBus control port with register file, Avalon access and two GPIO pins.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A full Write Byte loads the selected register, unless it is register 0, only at the stop.
// - Each GPIO is input or output by its own direction bit in register 2.
// - Output type bit picks open-drain low-only or push-pull drive.
// - Register 1 shows the sampled level of each pin, any direction.
// - Register 1 holds and reads back the intended drive of each pin.
// - Pulses of 50 ns or less on the bus lines never reach the engine.
// - With enable low the port ignores the bus and drives nothing.
// - A repeated start before the stop cancels the pending write.
// - Own address is 1,0 then five bits from three three-level straps.
// - Broadcast address 1011101 writes too, unless its enable bit is 0.
// - The alert response address is recognised and answered.
module smg_top
  import smg_pkg::*;
(
  // System clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Avalon-MM register slave, byte addressed.
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Upstream two-wire bus, handled on the link clock.
  input wire logic LINK_CLK,
  input wire logic ENABLE,
  input wire logic ALERT_PENDING,
  input wire logic UPSTREAM_CLOCK_LINE,
  input wire logic UPSTREAM_DATA_LINE_I,
  output logic UPSTREAM_DATA_LINE_O,
  output logic UPSTREAM_DATA_LINE_OE,
  // Address straps: 0 low, 1 high, 2 open.
  input wire logic [1:0] ADDRESS_SELECT_PIN0,
  input wire logic [1:0] ADDRESS_SELECT_PIN1,
  input wire logic [1:0] ADDRESS_SELECT_PIN2,
  // General-purpose pins.
  input wire logic GENERAL_PIN_ONE_I,
  output logic GENERAL_PIN_ONE_O,
  output logic GENERAL_PIN_ONE_OE,
  input wire logic GENERAL_PIN_TWO_I,
  output logic GENERAL_PIN_TWO_O,
  output logic GENERAL_PIN_TWO_OE
);

  //////////////////////////////////////////////////////////////////////////
  // System clock side: register file and bus slave.

  logic en1_q, en_q, ack_q, req_tgl_q, ak1_q, ak_q;
  logic wt1_q, wt2_q, wt3_q;
  logic [7:0] regs_q [0:3];
  logic [31:0] rdata_q, hold_q;
  logic [1:0] widx_q;
  logic [7:0] wdat_q;
  logic seen_q, wt_q;
  smg_gpio_if gp ();

  always_ff @(posedge CLK) begin
    en1_q <= ENABLE;
    en_q <= en1_q;
  end

  wire logic [1:0] av_idx = AVS_ADDRESS[3:2];
  wire logic av_hit = !AVS_ADDRESS[4];
  wire logic av_req = AVS_READ | AVS_WRITE;
  wire logic i2c_wr = wt2_q ^ wt3_q;
  wire logic av_wr = av_req & ack_q & AVS_WRITE & av_hit & AVS_BYTEENABLE[0];

  // Bus writes, committed once the stop toggle arrives.
  for (genvar g = 0; g < 4; g++) begin : g_reg
    wire logic i2_sel = (g != 0) && i2c_wr && widx_q == 2'(g);
    wire logic av_sel = (g != 0) && av_wr && av_idx == 2'(g);
    always_ff @(posedge CLK) begin
      if (!RST_N || !en_q) begin
        regs_q[g] <= REG_RST[g];
      end else if (i2_sel) begin
        regs_q[g] <= wdat_q;
      end else if (av_sel) begin
        regs_q[g] <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // Level bits overlay the stored byte; drive bits stay.
  wire logic [7:0] lvl_mask = 8'(8'h03 << LVL_LSB);
  wire logic [7:0] lvl_bits = 8'({6'h00, gp.level} << LVL_LSB);
  wire logic [7:0] gpio_view = (regs_q[REG_GPIO] & ~lvl_mask) | lvl_bits;
  wire logic [7:0] rd_byte = av_idx == REG_GPIO ? gpio_view : regs_q[av_idx];

  // One wait state; a write arriving from the bus side adds one more.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= av_req & !ack_q & !i2c_wr;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= 32'h0;
    end else if (av_req && !ack_q) begin
      rdata_q <= av_hit ? {24'h000000, rd_byte} : 32'h0;
    end
  end

  assign AVS_WAITREQUEST = av_req & !ack_q;
  assign AVS_READDATA = rdata_q;

  assign gp.dir_in = regs_q[REG_CFG][CFG_DIR_LSB +: 2];
  assign gp.push_pull = regs_q[REG_CFG][CFG_PP_LSB +: 2];
  assign gp.drive = regs_q[REG_GPIO][DRV_LSB +: 2];

  smg_gpio_drv u_gpio (
    .clk(CLK),
    .rst_n(RST_N),
    .gp(gp.drv),
    .pin_i({GENERAL_PIN_TWO_I, GENERAL_PIN_ONE_I}),
    .pin_o({GENERAL_PIN_TWO_O, GENERAL_PIN_ONE_O}),
    .pin_oe({GENERAL_PIN_TWO_OE, GENERAL_PIN_ONE_OE})
  );

  // Register image handed to the link side by a toggle handshake.
  wire logic [31:0] live_w = {regs_q[3], regs_q[2], gpio_view, regs_q[0]};
  wire logic snap_idle = req_tgl_q == ak_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hold_q <= 32'h0;
      req_tgl_q <= 1'h0;
    end else if (snap_idle && hold_q != live_w) begin
      hold_q <= live_w;
      req_tgl_q <= !req_tgl_q;
    end
  end

  // Write data from the link side is held long before its toggle flips.
  always_ff @(posedge CLK) begin
    ak1_q <= seen_q;
    ak_q <= ak1_q;
    wt1_q <= wt_q;
    wt2_q <= wt1_q;
    wt3_q <= wt2_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Link clock side: filters, straps and the serial engine.

  logic lr1_q, lrst_n_q, len1_q, len_q, al1_q, al_q, rq1_q, rq_q;
  logic [5:0] a1_q, a_q;
  logic [31:0] snap_q;
  logic scl_w, sda_w, scl_q, sda_q;

  always_ff @(posedge LINK_CLK) begin
    lr1_q <= RST_N;
    lrst_n_q <= lr1_q;
    len1_q <= ENABLE;
    len_q <= len1_q;
    al1_q <= ALERT_PENDING;
    al_q <= al1_q;
    a1_q <= {ADDRESS_SELECT_PIN2, ADDRESS_SELECT_PIN1, ADDRESS_SELECT_PIN0};
    a_q <= a1_q;
    rq1_q <= req_tgl_q;
    rq_q <= rq1_q;
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n_q) begin
      snap_q <= 32'h0;
      seen_q <= 1'h0;
    end else if (rq_q != seen_q) begin
      snap_q <= hold_q;
      seen_q <= rq_q;
    end
  end

  smg_glitch_filter u_fscl (
    .clk(LINK_CLK),
    .rst_n(lrst_n_q),
    .pin(UPSTREAM_CLOCK_LINE),
    .level(scl_w)
  );

  smg_glitch_filter u_fsda (
    .clk(LINK_CLK),
    .rst_n(lrst_n_q),
    .pin(UPSTREAM_DATA_LINE_I),
    .level(sda_w)
  );

  always_ff @(posedge LINK_CLK) begin
    scl_q <= scl_w;
    sda_q <= sda_w;
  end

  // An illegal strap code is treated as open.
  function automatic logic [1:0] tri_code(input logic [1:0] p);
    return (p == 2'h3) ? PIN_NC : p;
  endfunction : tri_code

  wire logic [4:0] lut_idx = 5'(9 * tri_code(a_q[5:4])
    + 3 * tri_code(a_q[3:2]) + tri_code(a_q[1:0]));
  wire logic [6:0] own_addr = {OWN_TOP, ADDR_LUT[lut_idx]};

  wire logic start_w = scl_q & scl_w & sda_q & !sda_w;
  wire logic stop_w = scl_q & scl_w & !sda_q & sda_w;
  wire logic rise_w = !scl_q & scl_w;
  wire logic fall_w = scl_q & !scl_w;

  smg_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d, tx_q, tx_d, wdat_d;
  logic [1:0] sel_q, sel_d, widx_d;
  logic oe_q, oe_d, pend_q, pend_d, wt_d;

  wire logic [6:0] rx_addr = sr_q[7:1];
  wire logic rx_rd = sr_q[0];
  wire logic hit_own = rx_addr == own_addr;
  // Broadcast accepted only while its enable bit is set.
  wire logic hit_bc = rx_addr == BCAST_ADDR && !rx_rd && snap_q[BCAST_SNAP_BIT];
  // Alert response answered while an alert is pending.
  wire logic hit_ara = rx_addr == ARA_ADDR && rx_rd && al_q;
  wire logic [7:0] rd_snap = snap_q[{sel_q, 3'h0} +: 8];
  wire logic byte_end = fall_w && cnt_q == 4'h7;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    tx_d = tx_q;
    sel_d = sel_q;
    oe_d = oe_q;
    pend_d = pend_q;
    wt_d = wt_q;
    wdat_d = wdat_q;
    widx_d = widx_q;
    if (!len_q) begin
      st_d = ST_IDLE;
      oe_d = 1'h0;
      pend_d = 1'h0;
    // Any start drops a pending write.
    end else if (start_w) begin
      st_d = ST_ADDR;
      // The fall that ends a start acts like an ack slot before bit 7.
      cnt_d = 4'h8;
      oe_d = 1'h0;
      pend_d = 1'h0;
    end else if (stop_w) begin
      st_d = ST_IDLE;
      oe_d = 1'h0;
      pend_d = 1'h0;
      wt_d = wt_q ^ pend_q;
    end else if (st_q == ST_IDLE) begin
      oe_d = 1'h0;
    end else if (rise_w) begin
      if (cnt_q < 4'h8) begin
        sr_d = {sr_q[6:0], sda_w};
      end else if (st_q == ST_READ && sda_w) begin
        st_d = ST_WAIT;
      end
    end else if (byte_end) begin
      cnt_d = 4'h8;
      oe_d = 1'h0;
      case (st_q)
        ST_ADDR: begin
          oe_d = hit_own | hit_bc | hit_ara;
          st_d = !oe_d ? ST_WAIT : (rx_rd ? ST_READ : ST_CMD);
          tx_d = hit_ara ? {own_addr, 1'h0} : rd_snap;
        end
        ST_CMD: begin
          sel_d = sr_q[CMD_SEL_LSB +: 2];
          oe_d = 1'h1;
          st_d = ST_DATA;
        end
        ST_DATA: begin
          wdat_d = sr_q;
          widx_d = sel_q;
          pend_d = 1'h1;
          oe_d = 1'h1;
          st_d = ST_WAIT;
        end
        default: begin
          oe_d = 1'h0;
        end
      endcase
    end else if (fall_w && cnt_q == 4'h8) begin
      cnt_d = 4'h0;
      oe_d = st_q == ST_READ && !tx_q[7];
    end else if (fall_w) begin
      cnt_d = cnt_q + 4'h1;
      oe_d = st_q == ST_READ && !tx_q[3'(3'h6 - cnt_q[2:0])];
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n_q) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      oe_q <= 1'h0;
      pend_q <= 1'h0;
      wt_q <= 1'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      wt_q <= wt_d;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    sr_q <= sr_d;
    tx_q <= tx_d;
    sel_q <= sel_d;
    wdat_q <= wdat_d;
    widx_q <= widx_d;
  end

  assign UPSTREAM_DATA_LINE_O = 1'h0;
  assign UPSTREAM_DATA_LINE_OE = oe_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  write_at_stop_a: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n_q)
    $changed(wt_q) |-> $past(stop_w) && $past(pend_q))
    else $error("Register write issued without a stop.");

  level_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == {1'h0, REG_GPIO}
    |-> AVS_READDATA[LVL_LSB +: 2] == $past(gp.level))
    else $error("Pin level bits do not match the sampled pins.");

  drive_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == {1'h0, REG_GPIO}
    |-> AVS_READDATA[DRV_LSB +: 2] == $past(gp.drive))
    else $error("Drive bits do not read back the intended drive.");

  disabled_idle_a: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n_q)
    !len_q |=> !UPSTREAM_DATA_LINE_OE && st_q == ST_IDLE)
    else $error("Data line driven while disabled.");

  restart_drop_a: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n_q)
    len_q && start_w |=> !pend_q && st_q == ST_ADDR ##1 $stable(wt_q))
    else $error("Pending write survived a repeated start.");

  own_ack_a: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n_q)
    len_q && !start_w && !stop_w && st_q == ST_ADDR && byte_end && hit_own
    |=> oe_q && st_q != ST_WAIT)
    else $error("Own address not acknowledged.");

  bcast_mask_a: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n_q)
    len_q && !start_w && !stop_w && st_q == ST_ADDR && byte_end
    && rx_addr == BCAST_ADDR && !snap_q[BCAST_SNAP_BIT]
    |=> !oe_q && st_q == ST_WAIT)
    else $error("Masked broadcast was acknowledged.");

  ara_reply_a: assert property (
    @(posedge LINK_CLK) disable iff (!lrst_n_q)
    len_q && !start_w && !stop_w && st_q == ST_ADDR && byte_end && hit_ara
    |=> st_q == ST_READ && tx_q == {own_addr, 1'h0})
    else $error("Alert response did not load the own address.");

  wait_bound_a: assert property (@(posedge CLK) disable iff (!RST_N)
    av_req |-> ##[0:2] !AVS_WAITREQUEST)
    else $error("Bus access held off too long.");

  write_commit_c: cover property (@(posedge CLK) disable iff (!RST_N)
    i2c_wr);

  read_nack_c: cover property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
    st_q == ST_READ ##1 st_q == ST_WAIT);

  ara_seen_c: cover property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
    byte_end && st_q == ST_ADDR && hit_ara);

  forced_low_c: cover property (@(posedge CLK) disable iff (!RST_N)
    gp.drive[1] && !gp.level[1] && !gp.dir_in[1]);

endmodule : smg_top

`default_nettype wire

// File: smg_bus_master.sv
// Behavioural upstream two-wire master that frames bytes for the bench.
`timescale 1ns/1ps
`default_nettype none

module smg_bus_master (
  // Link clock and sensed data level.
  input wire logic lclk,
  input wire logic sda_in,
  // Clock line and open-drain data drive, 1 releases the line.
  output logic scl,
  output logic sda_o
);
  // The bus clock idles high between frames, never free running.
  localparam int QTR = 20;
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic qtr();
    repeat (QTR) @(posedge lclk);
  endtask : qtr
  task automatic start();
    sda_o <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_o <= 1'b0;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start
  task automatic stop();
    sda_o <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_o <= 1'b1;
    qtr();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda_in;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : bit_io
  // Eight bits out, then the acknowledge slot left released.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, ack);
    ack = ~ack;
  endtask : xfer
  // A 48 ns high spike with the clock high would read as a stop.
  task automatic glitch();
    sda_o <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_o <= 1'b1;
    repeat (4) @(posedge lclk);
    sda_o <= 1'b0;
    qtr();
  endtask : glitch
endmodule : smg_bus_master

`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the SMBus control port with two GPIO pins.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic enable = 1'b1;
  logic alert = 1'b0;
  logic [1:0] st = 2'h0;
  logic [1:0] ext_low = 2'h0;
  wire logic [31:0] rdata;
  wire logic waitreq;
  wire logic scl;
  wire logic sda_m;
  wire logic sda_oe;
  wire logic sda_o;
  wire logic sda_line;
  wire logic [1:0] gp_o;
  wire logic [1:0] gp_oe;
  wire logic [1:0] gp_lvl;
  int err_total = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;
  initial begin
    #3.7;
    forever #6 lclk = ~lclk;
  end
  // Both pins and the data line have pull-ups.
  assign gp_lvl = (gp_oe & gp_o) | (~gp_oe & ~ext_low);
  assign sda_line = sda_m & ~(sda_oe & ~sda_o);

  smg_top u_dut (
    .CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .LINK_CLK(lclk),
    .ENABLE(enable), .ALERT_PENDING(alert), .UPSTREAM_CLOCK_LINE(scl),
    .UPSTREAM_DATA_LINE_I(sda_line), .UPSTREAM_DATA_LINE_O(sda_o),
    .UPSTREAM_DATA_LINE_OE(sda_oe), .ADDRESS_SELECT_PIN0(st),
    .ADDRESS_SELECT_PIN1(st), .ADDRESS_SELECT_PIN2(st),
    .GENERAL_PIN_ONE_I(gp_lvl[0]), .GENERAL_PIN_ONE_O(gp_o[0]),
    .GENERAL_PIN_ONE_OE(gp_oe[0]), .GENERAL_PIN_TWO_I(gp_lvl[1]),
    .GENERAL_PIN_TWO_O(gp_o[1]), .GENERAL_PIN_TWO_OE(gp_oe[1]));
  smg_bus_master u_mst (.lclk(lclk), .sda_in(sda_line), .scl(scl),
    .sda_o(sda_m));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Lets one edge pass, raises the request and holds it until waitrequest
  // is seen low at a rising edge; read data are taken at that same edge.
  task automatic av(input logic w, input logic [4:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : av
  task automatic awr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
    repeat (4) @(posedge clk);
  endtask : awr
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rchk
  task automatic bwr(input logic [6:0] a, input logic [7:0] c,
                     input logic [7:0] d, input logic sr,
                     output logic [2:0] k);
    logic [7:0] x;
    u_mst.start();
    u_mst.xfer({a, 1'b0}, x, k[2]);
    u_mst.xfer(c, x, k[1]);
    u_mst.xfer(d, x, k[0]);
    if (sr) u_mst.start();
    u_mst.stop();
    repeat (24) @(posedge clk);
  endtask : bwr

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk({30'h0, gp_oe}, 32'h0);
    rchk(5'h04, 32'h33);
    rchk(5'h08, 32'h13);
    awr(5'h00, 8'hFF);
    awr(5'h1C, 8'hFF);
    rchk(5'h00, 32'h00);
    rchk(5'h1C, 32'h00);
    rchk(5'h0C, 32'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_gpio();
    awr(5'h08, 8'h14);
    awr(5'h04, 8'h01);
    chk({28'h0, gp_oe, gp_o}, 32'hD);
    awr(5'h04, 8'h02);
    chk({29'h0, gp_oe, gp_o[0]}, 32'h2);
    rchk(5'h04, 32'h22);
    ext_low <= 2'b10;
    repeat (4) @(posedge clk);
    rchk(5'h04, 32'h02);
    awr(5'h08, 8'h17);
    chk({30'h0, gp_oe}, 32'h0);
    rchk(5'h04, 32'h12);
    ext_low <= 2'b00;
    $display("test gpio done");
  endtask : t_gpio
  // No channels here; switch bits are plain storage.
  task automatic t_write();
    logic [7:0] x;
    logic [2:0] k;
    logic n;
    u_mst.start();
    u_mst.xfer(8'h88, x, k[2]);
    u_mst.xfer(8'h03, x, k[1]);
    u_mst.xfer(8'hA5, x, k[0]);
    chk({29'h0, k}, 32'h7);
    u_mst.glitch();
    repeat (24) @(posedge clk);
    rchk(5'h0C, 32'h00);
    u_mst.stop();
    repeat (24) @(posedge clk);
    rchk(5'h0C, 32'hA5);
    bwr(7'h45, 8'h03, 8'h11, 1'b0, k);
    chk({31'h0, k[2]}, 32'h0);
    st <= 2'h1;
    bwr(7'h55, 8'h03, 8'h5A, 1'b0, k);
    chk({29'h0, k}, 32'h7);
    bwr(7'h55, 8'hFE, 8'h1F, 1'b0, k);
    rchk(5'h08, 32'h1F);
    bwr(7'h55, 8'h03, 8'hC3, 1'b1, k);
    rchk(5'h0C, 32'h5A);
    u_mst.start();
    u_mst.xfer(8'hAA, x, k[2]);
    u_mst.xfer(8'h03, x, k[1]);
    u_mst.start();
    u_mst.xfer(8'hAB, x, k[0]);
    u_mst.xfer(8'hFF, x, n);
    u_mst.stop();
    chk({21'h0, k, x}, 32'h75A);
    $display("test write done");
  endtask : t_write
  task automatic t_bcast();
    logic [2:0] k;
    bwr(7'h5D, 8'h03, 8'h3C, 1'b0, k);
    rchk(5'h0C, 32'h3C);
    awr(5'h08, 8'h03);
    repeat (24) @(posedge clk);
    bwr(7'h5D, 8'h03, 8'h77, 1'b0, k);
    chk({31'h0, k[2]}, 32'h0);
    rchk(5'h0C, 32'h3C);
    awr(5'h08, 8'h13);
    $display("test broadcast done");
  endtask : t_bcast
  task automatic t_ara();
    logic [7:0] x;
    logic [7:0] d;
    logic k;
    logic n;
    alert <= 1'b1;
    repeat (8) @(posedge clk);
    u_mst.start();
    u_mst.xfer(8'h19, x, k);
    u_mst.xfer(8'hFF, d, n);
    u_mst.stop();
    chk({23'h0, k, d}, 32'h1AA);
    alert <= 1'b0;
    $display("test alert done");
  endtask : t_ara
  task automatic t_en();
    logic [2:0] k;
    @(posedge clk);
    enable <= 1'b0;
    repeat (8) @(posedge clk);
    bwr(7'h55, 8'h03, 8'h99, 1'b0, k);
    chk({29'h0, k}, 32'h0);
    rchk(5'h0C, 32'h00);
    enable <= 1'b1;
    $display("test enable done");
  endtask : t_en

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (24) @(posedge clk);
    t_regs();
    t_gpio();
    t_write();
    t_bcast();
    t_ara();
    t_en();
    results();
  end
  // About three and a half times the expected run.
  initial begin
    #1000000;
    err_total++;
    results();
  end
endmodule : tb_top

`default_nettype wire
